// *** core/dlc_ctrl.v ***
// two-wire slave and per-section control and status registers
`timescale 1ns/10ps
`include "dlc_regs.vh"
module dlc_ctrl (
	input wire SYS_CLK_I,
	input wire RESET_N_I,
	input wire SCL_I,
	input wire SDA_I,
	output wire SDA_O,
	output wire SDA_OE_N_O,
	input wire [1:0] ADDR_SEL_A_I,
	input wire [1:0] ADDR_SEL_B_I,
	input wire UNDERVOLTAGE_LOCKOUT_I,
	input wire TONE_GATE_IN_A_I,
	input wire TONE_GATE_IN_B_I,
	input wire OVERTEMP_A_I,
	input wire OVERTEMP_B_I,
	input wire OVERLOAD_A_I,
	input wire OVERLOAD_B_I,
	output reg POWER_EN_A_O,
	output reg POWER_EN_B_O,
	output reg [1:0] LEVEL_A_O,
	output reg [1:0] LEVEL_B_O,
	output reg TONE_OUTPUT_A_O,
	output reg TONE_OUTPUT_B_O,
	output reg EXT_MOD_EN_A_O,
	output reg EXT_MOD_EN_B_O,
	output reg STATIC_LIMIT_A_O,
	output reg STATIC_LIMIT_B_O
);
	////////////////////////////////////////////////////////////////////////////
	// states, one-hot
	// idle   - waiting for a start; the data line is released
	// addr   - shifting in seven address bits and the read/write bit
	// wdata  - shifting in a control byte for the selected section
	// rdata  - shifting out the read image, one bit per clock fall
	// ack    - our pull-down slot after a byte, or the load of a read byte
	// mack   - the master's acknowledge slot after a byte we sent
	// a stop from any state returns to idle, a start from any state restarts
	// the address phase, so a master that aborts mid-byte never wedges us
	// the serial engine runs entirely on the system clock; the bus clock is
	// only sampled, so its low phase must cover the synchroniser delay plus
	// one cycle for the pull-down to settle before the master samples it
	localparam ST_IDLE = 6'h01;
	localparam ST_ADDR = 6'h02;
	localparam ST_WDATA = 6'h04;
	localparam ST_RDATA = 6'h08;
	localparam ST_ACK = 6'h10;
	localparam ST_MACK = 6'h20;

	wire [1:0] scl_sda_s;
	wire [1:0] addr_a_s;
	wire [1:0] addr_b_s;
	wire [6:0] misc_s;
	wire scl_s = scl_sda_s[1];
	wire sda_s = scl_sda_s[0];
	wire uvl_s = misc_s[6];

	// every pin passes two flops; the tone gates are async too
	dlc_sync #(.WIDTH(2)) u_sync_bus (
		.clk_i(SYS_CLK_I),
		.reset_n_i(RESET_N_I),
		.async_i({SCL_I, SDA_I}),
		.sync_o(scl_sda_s)
	);
	dlc_sync #(.WIDTH(4)) u_sync_addr (
		.clk_i(SYS_CLK_I),
		.reset_n_i(RESET_N_I),
		.async_i({ADDR_SEL_A_I, ADDR_SEL_B_I}),
		.sync_o({addr_a_s, addr_b_s})
	);
	dlc_sync #(.WIDTH(7)) u_sync_misc (
		.clk_i(SYS_CLK_I),
		.reset_n_i(RESET_N_I),
		.async_i({UNDERVOLTAGE_LOCKOUT_I, TONE_GATE_IN_A_I, TONE_GATE_IN_B_I,
			OVERTEMP_A_I, OVERTEMP_B_I, OVERLOAD_A_I, OVERLOAD_B_I}),
		.sync_o(misc_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// edge detection on synchronised lines
	reg scl_d_reg;
	reg sda_d_reg;
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// address match: fixed upper five bits plus that section's select pins
	function [1:0] addr_hit;
		input [6:0] addr;
		input [1:0] sel_a;
		input [1:0] sel_b;
		begin
			addr_hit[0] = (addr[6:2] == `DLC_ADDR_HI) && (addr[1:0] == sel_a);
			addr_hit[1] = (addr[6:2] == `DLC_ADDR_HI) && (addr[1:0] == sel_b);
		end
	endfunction

	// read image: factory bits zero, echoed controls, live faults
	function [7:0] read_image;
		input [7:0] sr;
		input ot;
		input ol;
		begin
			read_image = {3'h0, sr[`DLC_BIT_LINE_COMP], sr[`DLC_BIT_VOLTAGE_HIGH_SELECT], sr[`DLC_BIT_POWER_EN], ot, ol};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// serial engine
	reg [5:0] state_reg, state_next;
	reg [7:0] shift_reg, shift_next;
	reg [2:0] bit_cnt_reg, bit_cnt_next;
	reg rd_mode_reg, rd_mode_next;
	reg sec_b_reg, sec_b_next;
	reg addr_phase_reg, addr_phase_next;
	reg sda_low_reg, sda_low_next;
	reg [7:0] sr_a_reg, sr_a_next;
	reg [7:0] sr_b_reg, sr_b_next;
	reg [1:0] hit;

	// registers and state; lockout forces idle and zero registers
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			rd_mode_reg <= 1'b0;
			sec_b_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			sr_a_reg <= `DLC_SR_RESET;
			sr_b_reg <= `DLC_SR_RESET;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			rd_mode_reg <= rd_mode_next;
			sec_b_reg <= sec_b_next;
			addr_phase_reg <= addr_phase_next;
			sda_low_reg <= sda_low_next;
			sr_a_reg <= sr_a_next;
			sr_b_reg <= sr_b_next;
		end
	end

	// next-state logic; outside lockout the data pull-down moves only on clock falls
	// addr_phase_reg flags that eight bits have been shifted in; it is set on
	// the eighth bus clock rise and cleared when the ack slot ends, so the
	// clock fall that closes a start condition cannot be taken for a byte end
	// lockout has top priority so a sagging supply aborts any transfer at once
	always @* begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		rd_mode_next = rd_mode_reg;
		sec_b_next = sec_b_reg;
		addr_phase_next = addr_phase_reg;
		sda_low_next = sda_low_reg;
		sr_a_next = sr_a_reg;
		sr_b_next = sr_b_reg;
		hit = addr_hit(shift_reg[7:1], addr_a_s, addr_b_s);
		if (uvl_s) begin
			// lockout: ignore the bus, release data, hold registers zero
			state_next = ST_IDLE;
			sda_low_next = 1'b0;
			sr_a_next = `DLC_SR_RESET;
			sr_b_next = `DLC_SR_RESET;
		end else if (stop_det) begin
			state_next = ST_IDLE;
			sda_low_next = 1'b0;
		end else if (start_det) begin
			// a repeated start is treated as a fresh one, harmless here
			state_next = ST_ADDR;
			bit_cnt_next = 3'h0;
			addr_phase_next = 1'b0;
			sda_low_next = 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				sda_low_next = 1'b0;
			end
			ST_ADDR, ST_WDATA: begin
				if (scl_rise) begin
					shift_next = {shift_reg[6:0], sda_s};
					bit_cnt_next = bit_cnt_reg + 3'h1;
				end else if (scl_fall && addr_phase_reg) begin
					// eighth bit done, fall into the ack slot
					state_next = ST_ACK;
					if (state_reg == ST_ADDR) begin
						hit = addr_hit(shift_reg[7:1], addr_a_s, addr_b_s);
						if (hit != 2'h0) begin
							sec_b_next = ~hit[0];
							rd_mode_next = shift_reg[0];
							sda_low_next = 1'b1;
						end else begin
							state_next = ST_IDLE;
						end
					end else begin
						if (sec_b_reg)
							sr_b_next = shift_reg;
						else
							sr_a_next = shift_reg;
						sda_low_next = 1'b1;
					end
				end
				// eighth rise: the byte is complete once the clock falls again
				if (scl_rise && bit_cnt_reg == 3'h7)
					addr_phase_next = 1'b1;
			end
			ST_ACK: begin
				// hold low through the whole ack pulse; at its fall release for a write, or drive the first read bit
				if (scl_fall) begin
					addr_phase_next = 1'b0;
					bit_cnt_next = 3'h0;
					if (rd_mode_reg) begin
						shift_next = sec_b_reg ? read_image(sr_b_reg, misc_s[2], misc_s[0])
							: read_image(sr_a_reg, misc_s[3], misc_s[1]);
						state_next = ST_RDATA;
						sda_low_next = sec_b_reg ? ~shift_next[7] : ~shift_next[7];
					end else begin
						state_next = ST_WDATA;
						sda_low_next = 1'b0;
					end
				end
			end
			ST_RDATA: begin
				// shift out msb first, change only on clock fall
				if (scl_fall) begin
					bit_cnt_next = bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == 3'h7) begin
						state_next = ST_MACK;
						sda_low_next = 1'b0;
					end else begin
						shift_next = {shift_reg[6:0], 1'b0};
						sda_low_next = ~shift_reg[6];
					end
				end
			end
			ST_MACK: begin
				// master ack asks for another byte, nack ends the read
				if (scl_rise) begin
					state_next = sda_s ? ST_IDLE : ST_ACK;
					sda_low_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
			endcase
		end
	end

	// open-drain data: enable low while we pull the line low
	assign SDA_O = 1'b0;
	assign SDA_OE_N_O = ~sda_low_reg;

	////////////////////////////////////////////////////////////////////////////
	// section outputs decoded from the control registers
	function [6:0] section_out;
		input [7:0] sr;
		input gate;
		reg en;
		reg tone;
		begin
			en = sr[`DLC_BIT_POWER_EN];
			// continuous when both set, gated by the pin when only transmit is set, else off
			tone = sr[`DLC_BIT_TONE_TX] & (sr[`DLC_BIT_TONE_CONT] | gate);
			section_out[6] = en;
			section_out[5:4] = en ? {sr[`DLC_BIT_VOLTAGE_HIGH_SELECT], sr[`DLC_BIT_LINE_COMP]} : `DLC_LEVEL_13V3;
			section_out[3] = en & tone;
			section_out[2] = en & ~sr[`DLC_BIT_TONE_TX] & ~sr[`DLC_BIT_TONE_CONT];
			section_out[1] = en & sr[`DLC_BIT_LIMIT_STYLE];
			section_out[0] = 1'b0;
		end
	endfunction

	reg [6:0] out_a;
	reg [6:0] out_b;
	always @* begin
		out_a = section_out(sr_a_reg, misc_s[5]);
		out_b = section_out(sr_b_reg, misc_s[4]);
	end

	// outputs registered so they never glitch during decode
	always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			POWER_EN_A_O <= 1'b0;
			POWER_EN_B_O <= 1'b0;
			LEVEL_A_O <= `DLC_LEVEL_13V3;
			LEVEL_B_O <= `DLC_LEVEL_13V3;
			TONE_OUTPUT_A_O <= 1'b0;
			TONE_OUTPUT_B_O <= 1'b0;
			EXT_MOD_EN_A_O <= 1'b0;
			EXT_MOD_EN_B_O <= 1'b0;
			STATIC_LIMIT_A_O <= 1'b0;
			STATIC_LIMIT_B_O <= 1'b0;
		end else begin
			POWER_EN_A_O <= out_a[6];
			POWER_EN_B_O <= out_b[6];
			LEVEL_A_O <= out_a[5:4];
			LEVEL_B_O <= out_b[5:4];
			TONE_OUTPUT_A_O <= out_a[3];
			TONE_OUTPUT_B_O <= out_b[3];
			EXT_MOD_EN_A_O <= out_a[2];
			EXT_MOD_EN_B_O <= out_b[2];
			STATIC_LIMIT_A_O <= out_a[1];
			STATIC_LIMIT_B_O <= out_b[1];
		end
	end
endmodule // dlc_ctrl

// *** core/dlc_regs.vh ***
// constants for the dual supply controller two-wire front end
// Notes on behaviour
// - data changes only while clock low
// - detect start and stop while clock high
// - eight bits msb first, then ack slot
// - addressed device pulls data low during ack
// - no ack while undervoltage lockout active
// - address 00010 plus two select bits
// - one interface, address picks section
// - start, address with rw, data, stop
// - write image field order fixed
// - read image field order fixed
// - both registers clear at power on
// - write loads all eight bits
// - select and comp pick output level
// - tone gated by gate pin when non-continuous
// - continuous tone when both tone bits set
// - tone bits clear enable external modulation
// - tone output follows tone transmit bit
// - style bit picks pulsed or static limit
// - readback bits equal last written
// - fault flags read one while present
// - master ack requests another read byte
// - lockout ignores bus and zeroes registers
`ifndef DLC_REGS_VH
`define DLC_REGS_VH
`define DLC_ADDR_HI 5'h02
`define DLC_SR_RESET 8'h00
`define DLC_BIT_LIMIT_STYLE 7
`define DLC_BIT_TONE_TX 6
`define DLC_BIT_TONE_CONT 5
`define DLC_BIT_LINE_COMP 4
`define DLC_BIT_VOLTAGE_HIGH_SELECT 3
`define DLC_BIT_POWER_EN 2
`define DLC_BIT_FW4 1
`define DLC_BIT_FW5 0
`define DLC_LEVEL_13V3 2'h0
`define DLC_LEVEL_14V3 2'h1
`define DLC_LEVEL_18V2 2'h2
`define DLC_LEVEL_19V2 2'h3
`endif

// *** core/dlc_sync.v ***
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/10ps
module dlc_sync #(
	parameter WIDTH = 1
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage is read only by the second stage
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end
	assign sync_o = sync_reg;
endmodule // dlc_sync

// *** tb/dlc_ctrl_asserts.sv ***
// port-level checks for the two-wire control front end
`timescale 1ns/10ps
module dlc_ctrl_asserts (
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic SCL_I,
	input wire logic SDA_OE_N_O,
	input wire logic UNDERVOLTAGE_LOCKOUT_I,
	input wire logic POWER_EN_A_O,
	input wire logic POWER_EN_B_O,
	input wire logic [1:0] LEVEL_A_O,
	input wire logic [1:0] LEVEL_B_O,
	input wire logic TONE_OUTPUT_A_O,
	input wire logic EXT_MOD_EN_A_O
);
	default clocking dc @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	////////////////////////////////////////////////////////////////
	// every check samples at the system clock; async reset disables all
	a_reset_clear: assert property ($rose(RESET_N_I) |-> SDA_OE_N_O && !POWER_EN_A_O && !POWER_EN_B_O)
		else $error("outputs not cleared after reset");
	a_sda_steady: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
		else $error("data driven change while bus clock high");
	a_ack_hold: assert property ($fell(SDA_OE_N_O) |=> !SDA_OE_N_O [*4])
		else $error("data pull-down released too early");
	a_lockout_mute: assert property (UNDERVOLTAGE_LOCKOUT_I [*5] |-> SDA_OE_N_O)
		else $error("data driven during lockout");
	a_lockout_off: assert property (UNDERVOLTAGE_LOCKOUT_I [*6] |-> !POWER_EN_A_O && !POWER_EN_B_O)
		else $error("power on during lockout");
	a_power_a_gate: assert property (!POWER_EN_A_O |-> LEVEL_A_O == 2'h0)
		else $error("section a level set while power off");
	a_power_b_gate: assert property (LEVEL_B_O != 2'h0 |-> POWER_EN_B_O)
		else $error("section b level set while power off");
	a_ext_tone: assert property (EXT_MOD_EN_A_O |-> !TONE_OUTPUT_A_O)
		else $error("tone on with external path enabled");
endmodule // dlc_ctrl_asserts
bind dlc_ctrl dlc_ctrl_asserts u_chk (.*);

// *** tb/dlc_i2c_mst.sv ***
// two-wire bus master model for the microcontroller side
`timescale 1ns/10ps
module dlc_i2c_mst (
	output logic scl_o,
	output logic sda_o,
	input wire sda_i
);
	// idle bus: both lines released high, clock stands still
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// one slot of 200 ns: low phase kept long so a late pull-down still lands
	task automatic bit_slot(input logic b, output logic r);
		#25 sda_o = b;
		#100 scl_o = 1'b1;
		#37 r = sda_i;
		#38 scl_o = 1'b0;
	endtask
	task automatic start();
		#50 sda_o = 1'b0;
		#50 scl_o = 1'b0;
	endtask
	// always a stop before the next start, no repeated start
	task automatic stop();
		#25 sda_o = 1'b0;
		#100 scl_o = 1'b1;
		#50 sda_o = 1'b1;
		#50;
	endtask
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
		bit_slot(1'b1, r);
		ack = ~r;
	endtask
	task automatic rx(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
		bit_slot(~more, r);
	endtask
endmodule // dlc_i2c_mst

// *** tb/dlc_ctrl_tb.sv ***
// self-checking bench for the two-wire control front end
`timescale 1ns/10ps
module dlc_ctrl_tb;
	logic clk, rst_n, undervoltage_lockout;
	logic [1:0] sel_a, sel_b, gate, ot, ol;
	wire scl, msda, sda_o, sda_oe_n, pw_a, pw_b, tn_a, tn_b, ex_a, ex_b, st_a, st_b;
	wire [1:0] lv_a, lv_b;
	wire sda = msda & sda_oe_n;
	int n_mismatch, n_checks;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	dlc_i2c_mst m (.scl_o(scl), .sda_o(msda), .sda_i(sda));
	dlc_ctrl dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE_N_O(sda_oe_n), .ADDR_SEL_A_I(sel_a), .ADDR_SEL_B_I(sel_b), .UNDERVOLTAGE_LOCKOUT_I(undervoltage_lockout),
		.TONE_GATE_IN_A_I(gate[0]), .TONE_GATE_IN_B_I(gate[1]), .OVERTEMP_A_I(ot[0]), .OVERTEMP_B_I(ot[1]),
		.OVERLOAD_A_I(ol[0]), .OVERLOAD_B_I(ol[1]), .POWER_EN_A_O(pw_a), .POWER_EN_B_O(pw_b),
		.LEVEL_A_O(lv_a), .LEVEL_B_O(lv_b), .TONE_OUTPUT_A_O(tn_a), .TONE_OUTPUT_B_O(tn_b),
		.EXT_MOD_EN_A_O(ex_a), .EXT_MOD_EN_B_O(ex_b), .STATIC_LIMIT_A_O(st_a), .STATIC_LIMIT_B_O(st_b));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	// expected section outputs from a control byte: power off masks the rest
	function automatic logic [7:0] outs(input logic [7:0] d, input logic g);
		logic p;
		p = d[2];
		outs = {2'h0, p, p ? {d[3], d[4]} : 2'h0, p & d[6] & (d[5] | g), p & ~d[6] & ~d[5], p & d[7]};
	endfunction
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic ea);
		logic k;
		m.start();
		m.tx({a, 1'b0}, k);
		chk("address ack", {7'h0, ea}, {7'h0, k});
		if (k) m.tx(d, k);
		if (ea) chk("data ack", 8'h1, {7'h0, k});
		m.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d0, output logic [7:0] d1);
		logic k;
		m.start();
		m.tx({a, 1'b1}, k);
		chk("read ack", 8'h1, {7'h0, k});
		m.rx(1'b1, d0);
		m.rx(1'b0, d1);
		m.stop();
	endtask
	////////////////////////////////////////////////////////////////
	task automatic sc_reset();
		logic [7:0] r0, r1;
		chk("reset outputs", 8'h0, {pw_a, pw_b, lv_a, lv_b, tn_a, tn_b});
		chk("reset data drive", 8'h1, {6'h0, sda_o, sda_oe_n});
		rd({5'h02, sel_a}, r0, r1);
		chk("reset image", 8'h0, {3'h0, r0[4:0]});
	endtask
	// every level, tone and limit mode on section a, read back each time
	task automatic sc_modes();
		logic [7:0] tbl [8] = '{8'h04, 8'h14, 8'h0c, 8'h1c, 8'h44, 8'h64, 8'h84, 8'h18};
		logic [7:0] r0, r1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) #2;
			gate[0] = ~i[0];
			ot[0] = i[1];
			ol[0] = i[2];
			wr({5'h02, sel_a}, tbl[i], 1'b1);
			chk("outputs a", outs(tbl[i], gate[0]), {2'h0, pw_a, lv_a, tn_a, ex_a, st_a});
			rd({5'h02, sel_a}, r0, r1);
			chk("read image", {3'h0, tbl[i][4:2], ot[0], ol[0]}, {3'h0, r0[4:0]});
			chk("next byte", {3'h0, tbl[i][4:2], ot[0], ol[0]}, {3'h0, r1[4:0]});
		end
	endtask
	task automatic sc_sections();
		wr({5'h02, sel_b}, 8'h9c, 1'b1);
		chk("outputs b", outs(8'h9c, gate[1]), {2'h0, pw_b, lv_b, tn_b, ex_b, st_b});
		chk("outputs a kept", outs(8'h18, gate[0]), {2'h0, pw_a, lv_a, tn_a, ex_a, st_a});
		wr({5'h02, 2'h0}, 8'h04, 1'b0);
		wr({5'h03, sel_a}, 8'h04, 1'b0);
	endtask
	task automatic sc_lockout();
		logic [7:0] r0, r1;
		@(posedge clk) #2;
		undervoltage_lockout = 1'b1;
		repeat (8) @(posedge clk);
		chk("lockout power", 8'h0, {6'h0, pw_a, pw_b});
		wr({5'h02, sel_b}, 8'h04, 1'b0);
		@(posedge clk) #2;
		undervoltage_lockout = 1'b0;
		repeat (4) @(posedge clk);
		rd({5'h02, sel_b}, r0, r1);
		chk("image after lockout", 8'h0, {5'h0, r0[4:2]});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog: a hung bus counts as a mismatch
	initial begin
		#1ms;
		n_mismatch++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		undervoltage_lockout = 1'b0;
		sel_a = 2'h1;
		sel_b = 2'h3;
		gate = 2'h0;
		ot = 2'h0;
		ol = 2'h0;
		repeat (2) @(posedge clk);
		#2 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		sc_reset();
		sc_modes();
		sc_sections();
		sc_lockout();
		results();
	end
endmodule // dlc_ctrl_tb
